//--- core/acs_accum.sv
// Sample accumulator; sum_ff plus din_i is offered on next_o for same-cycle capture.
// Assumes clr_i and add_i are not asserted together.
`default_nettype none

module acs_accum #(
    parameter int DIN_W = 10,
    parameter int SUM_W = 16
) (
    input  wire logic             clk_i,   // Peripheral clock
    input  wire logic             rst_n_i, // Async reset, low
    input  wire logic             clr_i,   // Start a new burst
    input  wire logic             add_i,   // Add one sample
    input  wire logic [DIN_W-1:0] din_i,   // Sample value
    output logic      [SUM_W-1:0] next_o   // Sum including din_i
);
    logic [SUM_W-1:0] sum_ff;
    logic [SUM_W-1:0] nxt_sum;

    always_comb begin
        next_o  = sum_ff + SUM_W'(din_i);
        nxt_sum = sum_ff;
        if (clr_i) begin
            nxt_sum = '0;
        end else if (add_i) begin
            nxt_sum = next_o;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sum_ff <= '0;
        end else begin
            sum_ff <= nxt_sum;
        end
    end
endmodule : acs_accum

`default_nettype wire

//--- core/acs_prescaler.sv
// Converter-clock prescaler: one-cycle tick per rising converter edge.
// Assumes run is low whenever no conversion is active.
`default_nettype none

module acs_prescaler #(
    parameter int SEL_W = 3,
    parameter int CNT_W = 8
) (
    input  wire logic             clk_i,   // Peripheral clock
    input  wire logic             rst_n_i, // Async reset, low
    input  wire logic             run_i,   // Count enable
    input  wire logic [SEL_W-1:0] sel_i,   // Factor 2 << sel
    output logic                  tick_o   // Registered edge pulse
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             tick_ff;
    logic             nxt_tick;
    logic [CNT_W-1:0] half_m1;
    logic [CNT_W-1:0] full_m1;

    always_comb begin
        half_m1  = CNT_W'((CNT_W+1)'(1) << sel_i) - CNT_W'(1);
        full_m1  = CNT_W'(((CNT_W+1)'(2) << sel_i) - (CNT_W+1)'(1));
        nxt_tick = run_i && (cnt_ff == half_m1);
        if (!run_i) begin
            nxt_cnt = '0;
        end else if (cnt_ff == full_m1) begin
            nxt_cnt = '0;
        end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;
endmodule : acs_prescaler

`default_nettype wire

//--- core/acs_seq.sv
// Conversion sequencer: register port, start logic, converter timing,
// accumulation, input locking and result-ready interrupt.
// Assumes a synchronous register master and an analog core whose
// CONV_DATA_I is valid at the final converter cycle.
//
// Decided for this implementation: the plain strobed port and the address map.
`include "acs_map.svh"
`default_nettype none

// Functional notes
// - Start bit begins conversion, reads busy
// - Running conversion finishes on old input
// - Result ready set when burst ends
// - Interrupt needs flag enable and global enable
// - Flag sets even with interrupt disabled
// - Enabled events start conversions like software
// - Event edge sets start bit, single-mode completion clears
// - Continuous mode restarts right after completion
// - Prescaler counts only while enabled
// - Prescaler held idle; fixed start delay
// - Thirteen cycles, hold two cycles in
// - Sampling window two plus delay plus length
// - Result read or clear write drops flag
// - Result right aligned in result register
// - Selections lock at start, free last cycle
// - Continuous period thirteen plus delay plus length
module acs_seq
    import acs_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int CONV_W = 10
) (
    input  wire logic              REF_CLK_I,   // 10 MHz peripheral clock
    input  wire logic              RESETN_I,    // Async reset, low
    input  wire logic [3:0]        ADDR_I,      // Register index
    input  wire logic [DATA_W-1:0] WDATA_I,     // Write data
    input  wire logic              WR_I,        // Write strobe
    input  wire logic              RD_I,        // Read strobe
    output logic      [DATA_W-1:0] RDATA_O,     // Read data, next cycle
    input  wire logic              EVENT_I,     // Routed start event
    input  wire logic              GIE_I,       // Global interrupt enable
    input  wire logic [CONV_W-1:0] CONV_DATA_I, // Core conversion value
    output acs_core_t              CORE_O,      // Core controls
    output logic                   IRQ_O        // Level interrupt
);
    // ============================================================
    // State
    acs_cfg_t          cfg_ff, nxt_cfg;
    acs_state_t        state_ff, nxt_state;
    logic              start_ff, nxt_start;
    logic              flag_ff, nxt_flag;
    logic              evt_prev_ff;
    logic [8:0]        cyc_ff, nxt_cyc;
    logic [8:0]        total_ff, nxt_total;
    logic [8:0]        samp_end_ff, nxt_samp_end;
    logic [5:0]        smp_ff, nxt_smp;
    logic [6:0]        sel_act_ff, nxt_sel_act;
    logic              hold_ff, nxt_hold;
    logic [DATA_W-1:0] result_ff, nxt_result;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;

    logic              tick;
    logic              start_req;
    logic              evt_edge;
    logic              complete;
    logic              burst_end;
    logic [2:0]        acc_log;
    logic [5:0]        smp_last;
    logic [CONV_W-1:0] sample;
    logic [DATA_W-1:0] acc_next;
    logic              acc_clr;
    logic              clkdiv_run;

    // ============================================================
    // Submodules
    assign clkdiv_run = cfg_ff.enable && start_ff;

    acs_prescaler #(.SEL_W(3), .CNT_W(8)) u_clkdiv (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RESETN_I),
        .run_i   (clkdiv_run),
        .sel_i   (cfg_ff.div),
        .tick_o  (tick)
    );

    acs_accum #(.DIN_W(CONV_W), .SUM_W(DATA_W)) u_acc (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RESETN_I),
        .clr_i   (acc_clr),
        .add_i   (complete && !burst_end),
        .din_i   (sample),
        .next_o  (acc_next)
    );

    // ============================================================
    // Events of this cycle
    always_comb begin
        acc_log   = (cfg_ff.accum > `ACS_MAX_ACC_LOG) ? `ACS_MAX_ACC_LOG
                                                      : cfg_ff.accum;
        smp_last  = 6'(7'((7'd1 << acc_log) - 7'd1));
        // Reduced resolution keeps the upper bits, right aligned
        sample    = cfg_ff.res8 ? {2'h0, CONV_DATA_I[CONV_W-1:2]}
                                : CONV_DATA_I;
        start_req = WR_I && (ADDR_I == `ACS_OFS_COMMAND)
                    && WDATA_I[`ACS_START_BIT] && cfg_ff.enable;
        evt_edge  = EVENT_I && !evt_prev_ff && cfg_ff.evt_en
                    && cfg_ff.enable;
        complete  = (state_ff == ACS_RUN) && tick && cfg_ff.enable
                    && (cyc_ff == total_ff - 9'd1);
        burst_end = complete && (smp_ff == smp_last);
        acc_clr   = (state_ff == ACS_IDLE) || burst_end;
    end

    // ============================================================
    // Register writes and start bit
    always_comb begin
        nxt_cfg = cfg_ff;
        if (WR_I) begin
            unique case (ADDR_I)
                `ACS_OFS_CTL_A: begin
                    nxt_cfg.enable = WDATA_I[`ACS_CTL_A_EN_BIT];
                    nxt_cfg.cont   = WDATA_I[`ACS_CTL_A_CONT_BIT];
                    nxt_cfg.res8   = WDATA_I[`ACS_CTL_A_RES8_BIT];
                end
                `ACS_OFS_CTL_B:   nxt_cfg.accum  = WDATA_I[2:0];
                `ACS_OFS_CTL_C: begin
                    nxt_cfg.div     = WDATA_I[2:0];
                    nxt_cfg.ref_sel = WDATA_I[`ACS_CTL_C_REF_LSB+:2];
                end
                `ACS_OFS_CTL_D:   nxt_cfg.dly    = WDATA_I[3:0];
                `ACS_OFS_SAMPCTL: nxt_cfg.len    = WDATA_I[7:0];
                `ACS_OFS_MUXSEL:  nxt_cfg.muxsel = WDATA_I[4:0];
                `ACS_OFS_EVCTL:   nxt_cfg.evt_en = WDATA_I[`ACS_EVT_EN_BIT];
                `ACS_OFS_IRQ_EN:  nxt_cfg.irq_en = WDATA_I[`ACS_RDY_BIT];
                default: ;
            endcase
        end
        nxt_start = start_ff;
        if (burst_end && !cfg_ff.cont) begin
            nxt_start = 1'b0;
        end
        // A new start in the completing cycle wins over the clear
        if (start_req || evt_edge) begin
            nxt_start = 1'b1;
        end
        if (!cfg_ff.enable) begin
            nxt_start = 1'b0;
        end
        nxt_flag = flag_ff;
        if ((WR_I && (ADDR_I == `ACS_OFS_IRQ_CLR)
             && WDATA_I[`ACS_RDY_BIT])
            || (RD_I && (ADDR_I == `ACS_OFS_RESULT))) begin
            nxt_flag = 1'b0;
        end
        if (burst_end) begin
            nxt_flag = 1'b1;
        end
    end

    // ============================================================
    // Conversion sequencing
    always_comb begin
        nxt_state    = state_ff;
        nxt_cyc      = cyc_ff;
        nxt_total    = total_ff;
        nxt_samp_end = samp_end_ff;
        nxt_smp      = smp_ff;
        nxt_result   = result_ff;
        nxt_hold     = 1'b0;
        unique case (state_ff)
            ACS_IDLE: begin
                nxt_cyc      = '0;
                nxt_smp      = '0;
                nxt_total    = `ACS_CONV_CYCLES + 9'(cfg_ff.dly)
                               + 9'(cfg_ff.len);
                nxt_samp_end = `ACS_SH_CYCLES + 9'(cfg_ff.dly)
                               + 9'(cfg_ff.len);
                if (start_ff) begin
                    nxt_state = ACS_RUN;
                end
            end
            ACS_RUN: begin
                if (!cfg_ff.enable) begin
                    nxt_state = ACS_IDLE;
                end else if (complete) begin
                    nxt_cyc      = '0;
                    nxt_total    = `ACS_CONV_CYCLES + 9'(cfg_ff.dly)
                                   + 9'(cfg_ff.len);
                    nxt_samp_end = `ACS_SH_CYCLES + 9'(cfg_ff.dly)
                                   + 9'(cfg_ff.len);
                    nxt_smp      = burst_end ? 6'h00 : smp_ff + 6'h01;
                    if (burst_end) begin
                        nxt_result = acc_next;
                        if (!cfg_ff.cont && !(start_req || evt_edge)) begin
                            nxt_state = ACS_IDLE;
                        end
                    end
                end else if (tick) begin
                    nxt_cyc  = cyc_ff + 9'd1;
                    nxt_hold = (cyc_ff == samp_end_ff - 9'd1);
                end
            end
        endcase
        // Selections follow software while enabled, except during a conversion
        nxt_sel_act = sel_act_ff;
        if (cfg_ff.enable && ((state_ff == ACS_IDLE)
                              || (cyc_ff == total_ff - 9'd1))) begin
            nxt_sel_act = {cfg_ff.muxsel, cfg_ff.ref_sel};
        end
    end

    // ============================================================
    // Read port: data stand only in the cycle after the strobe
    always_comb begin
        nxt_rdata = `ACS_RST_DATA;
        if (RD_I) begin
            unique case (ADDR_I)
                `ACS_OFS_CTL_A:    nxt_rdata = DATA_W'({cfg_ff.res8,
                                       cfg_ff.cont, cfg_ff.enable});
                `ACS_OFS_CTL_B:    nxt_rdata = DATA_W'(cfg_ff.accum);
                `ACS_OFS_CTL_C:    nxt_rdata = DATA_W'({cfg_ff.ref_sel,
                                       1'b0, cfg_ff.div});
                `ACS_OFS_CTL_D:    nxt_rdata = DATA_W'(cfg_ff.dly);
                `ACS_OFS_SAMPCTL:  nxt_rdata = DATA_W'(cfg_ff.len);
                `ACS_OFS_MUXSEL:   nxt_rdata = DATA_W'(cfg_ff.muxsel);
                `ACS_OFS_COMMAND:  nxt_rdata = DATA_W'(start_ff);
                `ACS_OFS_EVCTL:    nxt_rdata = DATA_W'(cfg_ff.evt_en);
                `ACS_OFS_IRQ_EN:   nxt_rdata = DATA_W'(cfg_ff.irq_en);
                `ACS_OFS_IRQ_STAT: nxt_rdata = DATA_W'(flag_ff);
                `ACS_OFS_RESULT:   nxt_rdata = result_ff;
                default:           nxt_rdata = `ACS_RST_DATA;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cfg_ff      <= '0;
            state_ff    <= ACS_IDLE;
            start_ff    <= 1'b0;
            flag_ff     <= 1'b0;
            evt_prev_ff <= 1'b0;
            cyc_ff      <= '0;
            total_ff    <= `ACS_CONV_CYCLES;
            samp_end_ff <= `ACS_SH_CYCLES;
            smp_ff      <= '0;
            sel_act_ff  <= '0;
            hold_ff     <= 1'b0;
            result_ff   <= `ACS_RST_DATA;
            rdata_ff    <= `ACS_RST_DATA;
        end else begin
            cfg_ff      <= nxt_cfg;
            state_ff    <= nxt_state;
            start_ff    <= nxt_start;
            flag_ff     <= nxt_flag;
            evt_prev_ff <= EVENT_I;
            cyc_ff      <= nxt_cyc;
            total_ff    <= nxt_total;
            samp_end_ff <= nxt_samp_end;
            smp_ff      <= nxt_smp;
            sel_act_ff  <= nxt_sel_act;
            hold_ff     <= nxt_hold;
            result_ff   <= nxt_result;
            rdata_ff    <= nxt_rdata;
        end
    end

    // ============================================================
    // Outputs
    assign RDATA_O         = rdata_ff;
    assign IRQ_O           = flag_ff && cfg_ff.irq_en && GIE_I;
    // One driver for the struct; sel_act_ff packs mux then ref_sel
    assign CORE_O          = {cfg_ff.enable,
                              ((state_ff == ACS_RUN)
                               && (cyc_ff < samp_end_ff)),
                              hold_ff,
                              sel_act_ff};

    // ============================================================
    // Checks
    logic [8:0] since_start_ff;
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            since_start_ff <= '0;
        end else if (!start_ff) begin
            since_start_ff <= '0;
        end else if (since_start_ff <= (9'd1 << cfg_ff.div)) begin
            // Stops one past the first tick so later ticks are ignored
            since_start_ff <= since_start_ff + 9'd1;
        end
    end

    sequence s_cmd_start;
        start_req && !start_ff && (state_ff == ACS_IDLE);
    endsequence
    sequence s_first_tick;
        tick && start_ff && (since_start_ff <= (9'd1 << cfg_ff.div));
    endsequence

    property p_start_sets;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        s_cmd_start |=> start_ff ##1 (state_ff == ACS_RUN);
    endproperty
    a_start_sets: assert property (p_start_sets)
        else $error("start command did not set busy");

    property p_single_clear;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (burst_end && !cfg_ff.cont && !start_req && !evt_edge)
        |=> !start_ff && (state_ff == ACS_IDLE) && flag_ff;
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single conversion did not end cleanly");

    property p_sel_locked;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (state_ff == ACS_RUN && cyc_ff != total_ff - 9'd1)
        |=> $stable(sel_act_ff);
    endproperty
    a_sel_locked: assert property (p_sel_locked)
        else $error("input selection changed mid conversion");

    property p_irq_gate;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        burst_end && cfg_ff.irq_en && GIE_I |=> IRQ_O;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt not raised for ready result");

    property p_flag_poll;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        burst_end && !cfg_ff.irq_en |=> flag_ff && !IRQ_O;
    endproperty
    a_flag_poll: assert property (p_flag_poll)
        else $error("flag missing or interrupt while disabled");

    property p_event_level;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (!start_ff && !WR_I && EVENT_I && evt_prev_ff)
        |=> !start_ff;
    endproperty
    a_event_level: assert property (p_event_level)
        else $error("event level started a conversion");

    property p_event_start;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        evt_edge && !start_ff |=> start_ff;
    endproperty
    a_event_start: assert property (p_event_start)
        else $error("enabled event edge did not start");

    property p_clock_divider_select_idle;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        !start_ff |=> !tick && (u_clkdiv.cnt_ff == 8'h00);
    endproperty
    a_clock_divider_select_idle: assert property (p_clock_divider_select_idle)
        else $error("converter tick while no conversion");

    property p_start_delay;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        s_first_tick |-> since_start_ff == (9'd1 << cfg_ff.div);
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("start delay off");

    property p_cont_restart;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        complete && cfg_ff.cont |=> (state_ff == ACS_RUN)
            && (cyc_ff == 9'd0) && start_ff;
    endproperty
    a_cont_restart: assert property (p_cont_restart)
        else $error("continuous mode did not restart");

    property p_read_clears;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (RD_I && ADDR_I == `ACS_OFS_RESULT && !burst_end) |=> !flag_ff;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("result read did not clear flag");
endmodule : acs_seq

`default_nettype wire

//--- pkg/acs_map.svh
// Register offsets, field positions, reset values and timing counts
// for the conversion sequencer. Included by the core and the bench.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ============================================================
// Register offsets (word index on the 4-bit register port)
`define ACS_OFS_CTL_A      4'h0
`define ACS_OFS_CTL_B      4'h1
`define ACS_OFS_CTL_C      4'h2
`define ACS_OFS_CTL_D      4'h3
`define ACS_OFS_SAMPCTL    4'h4
`define ACS_OFS_MUXSEL     4'h5
`define ACS_OFS_COMMAND    4'h6
`define ACS_OFS_EVCTL      4'h7
`define ACS_OFS_IRQ_EN     4'h8
`define ACS_OFS_IRQ_STAT   4'h9
`define ACS_OFS_IRQ_CLR    4'ha
`define ACS_OFS_RESULT     4'hb

// ============================================================
// Field positions
`define ACS_CTL_A_EN_BIT   0
`define ACS_CTL_A_CONT_BIT 1
`define ACS_CTL_A_RES8_BIT 2
`define ACS_CTL_C_REF_LSB  4
`define ACS_RDY_BIT        0
`define ACS_START_BIT      0
`define ACS_EVT_EN_BIT     0

// ============================================================
// Reset values and timing in converter-clock cycles
`define ACS_RST_DATA       16'h0000
`define ACS_CONV_CYCLES    9'd13
`define ACS_SH_CYCLES      9'd2
`define ACS_MAX_ACC_LOG    3'd6

`endif

//--- pkg/acs_pkg.sv
// Types shared by the conversion sequencer core, the core model and the bench.
// Assumes acs_map.svh is on the include path.
`default_nettype none

package acs_pkg;
    // ============================================================
    // Sequencer states
    typedef enum logic [0:0] {
        ACS_IDLE = 1'b0,
        ACS_RUN  = 1'b1
    } acs_state_t;

    // ============================================================
    // Software configuration
    typedef struct packed {
        logic       enable;
        logic       cont;
        logic       res8;
        logic [2:0] accum;
        logic [2:0] div;
        logic [1:0] ref_sel;
        logic [3:0] dly;
        logic [7:0] len;
        logic [4:0] muxsel;
        logic       evt_en;
        logic       irq_en;
    } acs_cfg_t;

    // ============================================================
    // Controls toward the analog converter core
    typedef struct packed {
        logic       enable;
        logic       sampling;
        logic       hold;
        logic [4:0] mux;
        logic [1:0] ref_sel;
    } acs_core_t;
endpackage : acs_pkg

`default_nettype wire

//--- tb/acs_core_model.sv
// Behavioural analog core facing the sequencer core controls.
// Assumes the sequencer pulses hold once per sample.
`default_nettype none

module acs_core_model
    import acs_pkg::*;
(
    input  wire logic       clk_i,   // Peripheral clock
    input  wire logic       rst_n_i, // Async reset, low
    input  wire acs_core_t  core_i,  // Sequencer controls
    output logic      [9:0] data_o   // Conversion value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held_ff;

    // ============================================================
    // Sample and hold
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held_ff <= 10'h000;
        end else if (core_i.hold) begin
            held_ff <= {core_i.mux, core_i.mux} ^ 10'h2a5;
        end
    end
    // Disabled core does not keep showing its last value
    assign data_o = core_i.enable ? held_ff : ~held_ff;
endmodule : acs_core_model

`default_nettype wire

//--- tb/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer.
// Assumes acs_map.svh on the include path and the core model beside it.
`include "acs_map.svh"
`default_nettype none

module test_adc_conversion_sequencer;
    import acs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        REF_CLK_I, RESETN_I, WR_I, RD_I, EVENT_I, GIE_I, IRQ_O;
    logic [3:0]  ADDR_I;
    logic [15:0] WDATA_I, RDATA_O, rd_v;
    logic [9:0]  CONV_DATA_I;
    acs_core_t   CORE_O;
    int          err_total, compares, cyc, holds, last_hold, period, n;
    int          seed, dly, len, div, mux, rsel, samp_n, samp_len;
    int          exp_q[$];

    acs_seq u_dut (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .EVENT_I(EVENT_I), .GIE_I(GIE_I),
        .CONV_DATA_I(CONV_DATA_I), .CORE_O(CORE_O), .IRQ_O(IRQ_O));
    acs_core_model u_core (.clk_i(REF_CLK_I), .rst_n_i(RESETN_I),
        .core_i(CORE_O), .data_o(CONV_DATA_I));

    // ============================================================
    // Clock, hold-pulse monitor and hang guard
    initial begin
        REF_CLK_I = 1'b0;
        forever #50 REF_CLK_I = ~REF_CLK_I;
    end
    always @(posedge REF_CLK_I) begin
        cyc++;
        if (CORE_O.sampling === 1'b1) samp_n++;
        if (CORE_O.hold === 1'b1) begin
            period = cyc - last_hold;
            last_hold = cyc;
            samp_len = samp_n;
            samp_n = 0;
            holds++;
        end
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    // ============================================================
    // Bus, compare and model helpers
    function automatic int ev(input int m);
        return int'({m[4:0], m[4:0]} ^ 10'h2a5);
    endfunction : ev
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge REF_CLK_I);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_I    <= 1'b1;
        @(posedge REF_CLK_I);
        WR_I    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge REF_CLK_I);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        @(posedge REF_CLK_I);
        RD_I   <= 1'b0;
        @(posedge REF_CLK_I);
        rd_v = RDATA_O;
    endtask : rd
    // Polls status; reading it must not drop the flag
    task automatic wait_rdy();
        int k;
        k = 0;
        rd_v = 16'h0000;
        while (rd_v[0] !== 1'b1 && k < 300) begin
            rd(`ACS_OFS_IRQ_STAT);
            k++;
        end
        chk("status", rd_v, 16'h0001);
    endtask : wait_rdy
    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    // ============================================================
    // Scenarios
    initial begin
        {RESETN_I, WR_I, RD_I, EVENT_I, GIE_I} = 5'h00;
        ADDR_I = 4'h0;
        WDATA_I = 16'h0000;
        seed = 32'he6975144;
        repeat (2) @(posedge REF_CLK_I);
        RESETN_I <= 1'b1;
        rd(`ACS_OFS_RESULT);
        chk("result reset", rd_v, `ACS_RST_DATA);
        rd(4'hf);
        chk("unmapped", rd_v, 16'h0000);
        dly = $random(seed) & 3;
        len = $random(seed) & 7;
        mux = $random(seed) & 31;
        wr(`ACS_OFS_CTL_D, 16'(dly));
        wr(`ACS_OFS_SAMPCTL, 16'(len));
        wr(`ACS_OFS_MUXSEL, 16'(mux));
        wr(`ACS_OFS_CTL_A, 16'h0001);
        // Single run; input moved while busy must not affect it
        exp_q.push_back(ev(mux));
        wr(`ACS_OFS_COMMAND, 16'h0001);
        mux = mux ^ 1;
        wr(`ACS_OFS_MUXSEL, 16'(mux));
        rd(`ACS_OFS_COMMAND);
        chk("busy", rd_v, 16'h0001);
        wait_rdy();
        chk("irq masked", 16'(IRQ_O), 16'h0000);
        rd(`ACS_OFS_COMMAND);
        chk("start cleared", rd_v, 16'h0000);
        rd(`ACS_OFS_RESULT);
        chk("result", rd_v, 16'(exp_q.pop_front()));
        rd(`ACS_OFS_IRQ_STAT);
        chk("flag read", rd_v, 16'h0000);
        // Event starts, level held high, both global enables
        wr(`ACS_OFS_IRQ_EN, 16'h0001);
        wr(`ACS_OFS_EVCTL, 16'h0001);
        for (int g = 0; g < 2; g++) begin
            GIE_I <= g[0];
            wr(`ACS_OFS_CTL_A, 16'(1 | (g << 2)));
            holds = 0;
            exp_q.push_back(ev(mux) >> (2 * g));
            @(posedge REF_CLK_I);
            EVENT_I <= 1'b1;
            wait_rdy();
            chk("irq", 16'(IRQ_O), 16'(g));
            chk("one start", 16'(holds), 16'h0001);
            rd(`ACS_OFS_COMMAND);
            chk("no retrigger", rd_v, 16'h0000);
            EVENT_I <= 1'b0;
            wr(`ACS_OFS_IRQ_CLR, 16'h0001);
            rd(`ACS_OFS_IRQ_STAT);
            chk("flag clr", rd_v, 16'h0000);
            chk("irq low", 16'(IRQ_O), 16'h0000);
            rd(`ACS_OFS_RESULT);
            chk("ev result", rd_v, 16'(exp_q.pop_front()));
        end
        // Burst of four accumulated samples
        wr(`ACS_OFS_EVCTL, 16'h0000);
        // Burst still in 8-bit mode from the last event run
        wr(`ACS_OFS_CTL_B, 16'h0002);
        holds = 0;
        wr(`ACS_OFS_COMMAND, 16'h0001);
        wait_rdy();
        chk("burst", 16'(holds), 16'h0004);
        rd(`ACS_OFS_RESULT);
        chk("sum", rd_v, 16'(4 * (ev(mux) >> 2)));
        wr(`ACS_OFS_CTL_B, 16'h0000);
        // Continuous mode with a slower converter clock
        div = 1 + ($random(seed) & 1);
        rsel = $random(seed) & 3;
        wr(`ACS_OFS_CTL_C, 16'(div | (rsel << 4)));
        wr(`ACS_OFS_CTL_A, 16'h0003);
        wr(`ACS_OFS_COMMAND, 16'h0001);
        holds = 0;
        for (n = 0; n < 3000 && holds < 3; n++) @(posedge REF_CLK_I);
        chk("period", 16'(period), 16'((13 + dly + len) * (2 << div)));
        chk("samp", 16'(samp_len), 16'((2+dly+len) * (2 << div)));
        chk("reference_select", 16'(CORE_O.ref_sel), 16'(rsel));
        rd(`ACS_OFS_IRQ_STAT);
        chk("cont flag", rd_v, 16'h0001);
        wr(`ACS_OFS_CTL_A, 16'h0000);
        rd(`ACS_OFS_COMMAND);
        chk("abort", rd_v, 16'h0000);
        give_verdict();
    end
endmodule : test_adc_conversion_sequencer

`default_nettype wire
